// File: hdl/omc_ctrl.sv
// Operating-mode controller: select decode, deferred switching, busy and path gating
`timescale 1ns/1ns
module omc_ctrl
(
    input  wire logic                ref_clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                clk_en_i,
    input  wire logic                mode_select_low_i,
    input  wire logic                mode_select_high_i,
    input  wire logic                tx_pending_i,
    input  wire logic                rx_out_pending_i,
    input  wire logic                serial_in_active_i,
    output logic                     busy_n_o,
    output omc_pkg::omc_mode_e       mode_o,
    output logic                     tx_enable_o,
    output logic                     rx_enable_o,
    output logic                     wake_preamble_o,
    output logic                     cfg_access_o,
    output logic                     reapply_o
);
    import omc_pkg::*;

    // =========================================================
    // Select synchronisation
    // =========================================================
    logic [1:0] sel_sync;

    omc_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .clk_en_i  (clk_en_i),
        .async_i   ({mode_select_high_i, mode_select_low_i}),
        .sync_o    (sel_sync)
    );

    function automatic omc_mode_e decode_mode(input logic [1:0] sel);
        decode_mode = omc_mode_e'(sel);
    endfunction

    // =========================================================
    // Mode state machine
    // =========================================================
    omc_state_e              state_q;
    omc_state_e              state_d;
    omc_mode_e               mode_q;
    omc_mode_e               mode_d;
    omc_mode_e               target_q;
    omc_mode_e               target_d;
    logic [SWITCH_CNT_W-1:0] cnt_q;
    logic [SWITCH_CNT_W-1:0] cnt_d;
    logic                    busy_n_q;
    logic                    busy_n_d;
    logic                    tx_en_q;
    logic                    tx_en_d;
    logic                    rx_en_q;
    logic                    rx_en_d;
    logic                    pre_q;
    logic                    pre_d;
    logic                    cfg_q;
    logic                    cfg_d;
    logic                    reapply_q;
    logic                    reapply_d;
    logic                    work_busy;
    omc_mode_e               sel_mode;

    // Serial streaming counts as pending work so the new mode waits for it
    assign work_busy = tx_pending_i || rx_out_pending_i || serial_in_active_i;
    assign sel_mode  = decode_mode(sel_sync);

    always_comb begin
        state_d   = state_q;
        mode_d    = mode_q;
        target_d  = target_q;
        cnt_d     = cnt_q;
        unique case (state_q)
            OMC_ST_RUN: begin
                // A change seen while busy stays pending: the compare repeats every cycle
                if (sel_mode != mode_q && !work_busy) begin
                    target_d = sel_mode;
                    cnt_d    = '0;
                    state_d  = OMC_ST_SETTLE;
                end
            end
            OMC_ST_SETTLE: begin
                if (work_busy) begin
                    state_d = OMC_ST_RUN;
                end else if (cnt_q == SWITCH_CNT_W'(SWITCH_CYCLES - 1)) begin
                    mode_d = target_q;
                    if (mode_q == OMC_MODE_SLEEP && target_q != OMC_MODE_SLEEP) begin
                        cnt_d   = '0;
                        state_d = OMC_ST_REAPPLY;
                    end else begin
                        state_d = OMC_ST_RUN;
                    end
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            OMC_ST_REAPPLY: begin
                if (cnt_q == SWITCH_CNT_W'(REAPPLY_CYCLES - 1)) begin
                    state_d = OMC_ST_RUN;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: begin
                state_d = OMC_ST_RUN;
            end
        endcase
        if (!clk_en_i) begin
            state_d   = state_q;
            mode_d    = mode_q;
            target_d  = target_q;
            cnt_d     = cnt_q;
        end
    end

    // =========================================================
    // Output decode, registered
    // =========================================================
    always_comb begin
        busy_n_d = !(work_busy || state_d == OMC_ST_REAPPLY);
        // Same source as busy so the two edges of the re-apply window line up
        reapply_d = (state_d == OMC_ST_REAPPLY);
        tx_en_d  = (mode_d == OMC_MODE_NORMAL) || (mode_d == OMC_MODE_WAKE);
        rx_en_d  = (mode_d == OMC_MODE_NORMAL) || (mode_d == OMC_MODE_WAKE);
        pre_d    = (mode_d == OMC_MODE_WAKE);
        cfg_d    = (mode_d == OMC_MODE_CONFIG);
        if (state_d == OMC_ST_REAPPLY) begin
            tx_en_d = 1'b0;
            rx_en_d = 1'b0;
        end
        if (!clk_en_i) begin
            busy_n_d = busy_n_q;
            tx_en_d  = tx_en_q;
            rx_en_d  = rx_en_q;
            pre_d    = pre_q;
            cfg_d    = cfg_q;
            reapply_d = reapply_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q   <= OMC_ST_RUN;
            mode_q    <= MODE_RESET;
            target_q  <= MODE_RESET;
            cnt_q     <= '0;
            busy_n_q  <= 1'b0;
            tx_en_q   <= 1'b0;
            rx_en_q   <= 1'b0;
            pre_q     <= 1'b0;
            cfg_q     <= 1'b0;
            reapply_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            mode_q    <= mode_d;
            target_q  <= target_d;
            cnt_q     <= cnt_d;
            busy_n_q  <= busy_n_d;
            tx_en_q   <= tx_en_d;
            rx_en_q   <= rx_en_d;
            pre_q     <= pre_d;
            cfg_q     <= cfg_d;
            reapply_q <= reapply_d;
        end
    end

    assign busy_n_o        = busy_n_q;
    assign mode_o          = mode_q;
    assign tx_enable_o     = tx_en_q;
    assign rx_enable_o     = rx_en_q;
    assign wake_preamble_o = pre_q;
    assign cfg_access_o    = cfg_q;
    assign reapply_o       = reapply_q;

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    mode_hold_busy_a: assert property (clk_en_i && work_busy |=> $stable(mode_q))
        else $error("mode changed while work pending");
    sleep_no_radio_a: assert property (mode_q == OMC_MODE_SLEEP |-> ##1 !tx_en_q && !rx_en_q)
        else $error("radio active in sleep");
    cfg_no_radio_a: assert property (mode_q == OMC_MODE_CONFIG |-> !tx_en_q && !rx_en_q && cfg_q)
        else $error("config mode gating wrong");
    wake_preamble_a: assert property (mode_q == OMC_MODE_WAKE |-> pre_q && !cfg_q)
        else $error("preamble missing in wake mode");
    normal_paths_a: assert property (clk_en_i && state_d == OMC_ST_RUN
        && mode_d == OMC_MODE_NORMAL |=> tx_en_q && rx_en_q && !pre_q)
        else $error("normal paths not enabled");
    busy_pending_a: assert property (clk_en_i && work_busy |=> !busy_n_q)
        else $error("busy high with pending work");
    reapply_busy_a: assert property (reapply_q |-> !busy_n_q)
        else $error("busy high during reapply");
    settle_time_a: assert property ($rose(state_q == OMC_ST_SETTLE) && clk_en_i
        ##0 (clk_en_i && !work_busy)[*8] |-> mode_q == $past(mode_q, 8))
        else $error("mode switched too early");
    switch_sel_a: assert property (clk_en_i && state_q == OMC_ST_RUN && !work_busy
        && sel_mode != mode_q |=> state_q == OMC_ST_SETTLE && target_q == $past(sel_mode))
        else $error("change not taken when idle");

    switch_c: cover property (state_q == OMC_ST_SETTLE ##1 state_q == OMC_ST_RUN);
    sleep_c: cover property (mode_q == OMC_MODE_SLEEP);
    reapply_c: cover property ($rose(reapply_q));
    defer_c: cover property (work_busy && sel_mode != mode_q);
endmodule

// File: hdl/omc_pkg.sv
// Package: constants and types for the operating-mode controller
package omc_pkg;

    // Operating modes, code = {mode_select_high, mode_select_low}
    typedef enum logic [1:0] {
        OMC_MODE_NORMAL = 2'b00,
        OMC_MODE_WAKE   = 2'b01,
        OMC_MODE_CONFIG = 2'b10,
        OMC_MODE_SLEEP  = 2'b11
    } omc_mode_e;

    // Controller states
    typedef enum logic [1:0] {
        OMC_ST_RUN    = 2'b00,
        OMC_ST_SETTLE = 2'b01,
        OMC_ST_REAPPLY = 2'b10
    } omc_state_e;

    localparam int unsigned CLK_FREQ_HZ      = 10_000_000;
    localparam int unsigned SWITCH_TIME_US   = 1000;
    // Longest switching time rounds down
    localparam int unsigned SWITCH_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * SWITCH_TIME_US;
    localparam int unsigned SWITCH_CNT_W     = 14;
    localparam int unsigned REAPPLY_CYCLES   = 64;
    localparam int unsigned REAPPLY_CNT_W    = 7;

    localparam omc_mode_e   MODE_RESET       = OMC_MODE_NORMAL;
    localparam logic [1:0]  SYNC_RESET       = 2'h0;

endpackage

// File: hdl/omc_sync2.sv
// Two-flop synchroniser for the mode-select pins
`timescale 1ns/1ns
module omc_sync2 #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             clk_en_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = clk_en_i ? async_i : meta_q;
        sync_d = clk_en_i ? meta_q  : sync_q;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule

// File: dv/omc_host_model.sv
// Host model: drives the two mode-select pins, optionally pacing on busy
`timescale 1ns/1ns
module omc_host_model
    import omc_pkg::*;
#(
    parameter int unsigned HOLD_CYC = 20
) (
    input  wire logic ref_clk_i,
    input  wire logic busy_n_i,
    output logic      mode_select_low_o,
    output logic      mode_select_high_o
);
    initial begin
        mode_select_low_o  = 1'b0;
        mode_select_high_o = 1'b0;
    end
    // =========================================
    // Mode request
    // Shortened pacing: the full 2 ms guard would dominate the run time
    task automatic set_mode(input omc_mode_e m, input bit polite);
        if (polite) begin
            while (busy_n_i !== 1'b1) @(negedge ref_clk_i);
            repeat (HOLD_CYC) @(negedge ref_clk_i);
        end
        @(negedge ref_clk_i);
        {mode_select_high_o, mode_select_low_o} = m;
    endtask
endmodule

// File: dv/operating_mode_controller_tb.sv
// Self-checking testbench for the operating-mode controller
`timescale 1ns/1ns
module operating_mode_controller_tb;
    import omc_pkg::*;
    logic ref_clk_i, reset_n_i, clk_en_i, sel_lo, sel_hi;
    logic [2:0] pend;
    logic busy_n_o, tx_en, rx_en, pre, cfg, reapply;
    omc_mode_e mode_o;
    int error_cnt, tests_run, cyc;
    // =========================================
    // Clock, design and host
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    omc_ctrl u_omc_ctrl (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .mode_select_low_i(sel_lo), .mode_select_high_i(sel_hi),
        .tx_pending_i(pend[0]), .rx_out_pending_i(pend[1]),
        .serial_in_active_i(pend[2]), .busy_n_o(busy_n_o), .mode_o(mode_o),
        .tx_enable_o(tx_en), .rx_enable_o(rx_en), .wake_preamble_o(pre),
        .cfg_access_o(cfg), .reapply_o(reapply)
    );
    omc_host_model u_omc_host_model (
        .ref_clk_i(ref_clk_i), .busy_n_i(busy_n_o),
        .mode_select_low_o(sel_lo), .mode_select_high_o(sel_hi)
    );
    // =========================================
    // Checking helpers
    function automatic logic [3:0] exp_paths(input omc_mode_e m);
        case (m)
            OMC_MODE_NORMAL: return 4'hc;
            OMC_MODE_WAKE:   return 4'he;
            OMC_MODE_CONFIG: return 4'h1;
            default:         return 4'h0;
        endcase
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("Counts: %0d compared, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // =========================================
    // One mode switch, optionally with pending work held across it
    task automatic switch_to(input omc_mode_e m, input int src, input bit polite);
        omc_mode_e old;
        int n;
        old = mode_o;
        u_omc_host_model.set_mode(m, polite);
        if (src >= 0) begin
            pend[src] = 1'b1;
            n = 20 + ($urandom % 200);
            repeat (n) @(negedge ref_clk_i);
            check(busy_n_o, 1'b0);
            check(mode_o, old);
            pend[src] = 1'b0;
        end
        n = 0;
        while (mode_o !== m && n < SWITCH_CYCLES + 20) begin
            @(negedge ref_clk_i);
            n++;
        end
        // Lower bound proves the mode does not switch before the full SWITCH_CYCLES settle count
        check(n >= SWITCH_CYCLES && n <= SWITCH_CYCLES + 5, 1'b1);
        check(mode_o, m);
        if (old == OMC_MODE_SLEEP) begin
            check({reapply, busy_n_o, tx_en}, 3'h4);
            n = 0;
            while (busy_n_o !== 1'b1 && n < 200) begin
                @(negedge ref_clk_i);
                n++;
            end
            check(n >= REAPPLY_CYCLES - 2 && n <= REAPPLY_CYCLES + 2, 1'b1);
            check(reapply, 1'b0);
        end
        @(negedge ref_clk_i);
        check({tx_en, rx_en, pre, cfg}, exp_paths(m));
        $display("Test done: mode %0d, %0d mismatches so far", m, error_cnt);
    endtask
    // =========================================
    // Timeout and main sequence
    initial begin
        cyc = 0;
        forever begin
            @(posedge ref_clk_i);
            cyc++;
            if (cyc >= 90000) begin
                error_cnt++;
                results();
            end
        end
    end
    initial begin
        error_cnt = 0;
        tests_run = 0;
        reset_n_i = 1'b0;
        clk_en_i  = 1'b1;
        pend      = 3'h0;
        void'($urandom(67));
        repeat (10) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        check({mode_o, busy_n_o, tx_en, rx_en}, 5'h07);
        $display("Test done: reset state");
        switch_to(OMC_MODE_WAKE, -1, 1'b1);
        switch_to(OMC_MODE_CONFIG, 0, 1'b0);
        switch_to(OMC_MODE_SLEEP, 1, 1'b0);
        switch_to(OMC_MODE_NORMAL, 2, 1'b0);
        switch_to(OMC_MODE_SLEEP, -1, 1'b1);
        switch_to(omc_mode_e'(2'($urandom % 3)), -1, 1'b1);
        results();
    end
endmodule
